// ### psd_regs.svh
// register offsets, field positions and reset values for the scan/dwell/tx level block
// assumes byte-addressed axi4-lite, one 32-bit word per register
`ifndef PSD_REGS_SVH
`define PSD_REGS_SVH

// register indices; the bus byte address of each register is four times its index
`define PSD_IDX_TXLVL 10'h003
`define PSD_IDX_PSEL 10'h004
`define PSD_IDX_DWLO 10'h005
`define PSD_IDX_DWSEL 10'h006

`define PSD_OFF_TXLVL 12'h00c
`define PSD_OFF_PSEL 12'h010
`define PSD_OFF_DWLO 12'h014
`define PSD_OFF_DWSEL 12'h018
`define PSD_TXLVL_RST 4'h7
`define PSD_TXLVL_CEIL 4'hd
`define PSD_TXLVL_CLIP 4'he
`define PSD_MASK_RST 4'hf
`define PSD_DWHI_RST 4'h0
`define PSD_DWLO_RST 8'h52
`define PSD_DWSEL_RST 2'h1
`define PSD_DWSEL_USER 2'h3
`define PSD_DWHI_LSB 4
`define PSD_RESP_OKAY 2'h0
`define PSD_RESP_SLVERR 2'h2

`endif

// ### psd_pkg.sv
// types shared by the scan/dwell/tx level configuration block
// assumes psd_regs.svh supplies the numbers
package psd_pkg;
    typedef struct packed {
        logic [3:0] tx_level_code;
        logic [3:0] scan_include;
        logic [11:0] dwell_multiplier_low;
        logic [1:0] dwell_sel;
        logic tx_clip_warn;
    } psd_cfg_s;

    typedef struct packed {
        logic [11:0] addr;
        logic [31:0] data;
        logic [3:0] strb;
    } psd_wr_s;
endpackage : psd_pkg

// ### psd_cfg.sv
// axi4-lite register slice: tx level code, scan port masks, 12-bit user dwell multiplier
// assumes one clock, synchronous active-high reset, a scan engine driving port_arrive and consuming cfg
//
// Contract
// - 4-bit tx level code, 0x0 lowest
// - tx level code resets to 0x7
// - codes 0xE, 0xF above ceiling; 0xE clips
// - dwell bits 11:8 at bits 7:4
// - per-port mask bit, 1 keeps port
// - dwell bits 7:0 reset to 0x52
// - dwell select 0x3 uses user multiplier
//
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/1ps
`include "psd_regs.svh"

module psd_cfg (
    input wire logic clk,
    input wire logic rst,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic port_arrive,
    output psd_pkg::psd_cfg_s cfg,
    output logic [11:0] port_dwell_bits
);
    import psd_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // write channel capture
    logic aw_ok_ff, nxt_aw_ok;
    logic w_ok_ff, nxt_w_ok;
    logic [11:0] awaddr_ff, nxt_awaddr;
    logic [31:0] wdata_ff, nxt_wdata;
    logic [3:0] wstrb_ff, nxt_wstrb;
    logic bvalid_ff, nxt_bvalid;
    logic [1:0] bresp_ff, nxt_bresp;
    logic awready_ff, nxt_awready;
    logic wready_ff, nxt_wready;
    logic do_wr;
    psd_wr_s wr;

    // address and data may come in either order; the response waits for both
    always_comb begin
        nxt_aw_ok = aw_ok_ff;
        nxt_w_ok = w_ok_ff;
        nxt_awaddr = awaddr_ff;
        nxt_wdata = wdata_ff;
        nxt_wstrb = wstrb_ff;
        nxt_bvalid = bvalid_ff;
        nxt_bresp = bresp_ff;
        do_wr = 1'b0;
        if (s_axi_awvalid && !aw_ok_ff && !bvalid_ff) begin
            nxt_aw_ok = 1'b1;
            nxt_awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_ok_ff && !bvalid_ff) begin
            nxt_w_ok = 1'b1;
            nxt_wdata = s_axi_wdata;
            nxt_wstrb = s_axi_wstrb;
        end
        if (aw_ok_ff && w_ok_ff) begin
            do_wr = 1'b1;
            nxt_aw_ok = 1'b0;
            nxt_w_ok = 1'b0;
            nxt_bvalid = 1'b1;
            case (awaddr_ff)
                `PSD_OFF_TXLVL, `PSD_OFF_PSEL, `PSD_OFF_DWLO, `PSD_OFF_DWSEL: nxt_bresp = `PSD_RESP_OKAY;
                default: nxt_bresp = `PSD_RESP_SLVERR;
            endcase
        end
        if (bvalid_ff && s_axi_bready) begin
            nxt_bvalid = 1'b0;
        end
        // readies are registered so the bus sees them straight from flops
        nxt_awready = !nxt_aw_ok && !nxt_bvalid;
        nxt_wready = !nxt_w_ok && !nxt_bvalid;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            aw_ok_ff <= 1'b0;
            w_ok_ff <= 1'b0;
            awaddr_ff <= 12'h000;
            wdata_ff <= 32'h0000_0000;
            wstrb_ff <= 4'h0;
            bvalid_ff <= 1'b0;
            bresp_ff <= `PSD_RESP_OKAY;
            awready_ff <= 1'b1;
            wready_ff <= 1'b1;
        end else begin
            aw_ok_ff <= nxt_aw_ok;
            awready_ff <= nxt_awready;
            wready_ff <= nxt_wready;
            w_ok_ff <= nxt_w_ok;
            awaddr_ff <= nxt_awaddr;
            wdata_ff <= nxt_wdata;
            wstrb_ff <= nxt_wstrb;
            bvalid_ff <= nxt_bvalid;
            bresp_ff <= nxt_bresp;
        end
    end

    assign wr = '{addr: awaddr_ff, data: wdata_ff, strb: wstrb_ff};
    assign s_axi_awready = awready_ff;
    assign s_axi_wready = wready_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;

    ////////////////////////////////////////////////////////////////////////////
    // configuration registers; only byte lane 0 carries data
    logic [3:0] tx_level_code_ff, nxt_tx_level_code;
    logic [3:0] scan_include_ff, nxt_scan_include;
    logic [3:0] dwell_hi_ff, nxt_dwell_hi;
    logic [7:0] dwell_lo_ff, nxt_dwell_lo;
    logic [1:0] dwell_sel_ff, nxt_dwell_sel;
    logic lane0;

    always_comb begin
        lane0 = do_wr && wr.strb[0];
        nxt_tx_level_code = tx_level_code_ff;
        nxt_scan_include = scan_include_ff;
        nxt_dwell_hi = dwell_hi_ff;
        nxt_dwell_lo = dwell_lo_ff;
        nxt_dwell_sel = dwell_sel_ff;
        if (lane0) begin
            case (wr.addr)
                `PSD_OFF_TXLVL: nxt_tx_level_code = wr.data[3:0];
                `PSD_OFF_PSEL: begin
                    nxt_dwell_hi = wr.data[7:4];
                    nxt_scan_include = wr.data[3:0];
                end
                `PSD_OFF_DWLO: nxt_dwell_lo = wr.data[7:0];
                `PSD_OFF_DWSEL: nxt_dwell_sel = wr.data[1:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            tx_level_code_ff <= `PSD_TXLVL_RST;
            scan_include_ff <= `PSD_MASK_RST;
            dwell_hi_ff <= `PSD_DWHI_RST;
            dwell_lo_ff <= `PSD_DWLO_RST;
            dwell_sel_ff <= `PSD_DWSEL_RST;
        end else begin
            tx_level_code_ff <= nxt_tx_level_code;
            scan_include_ff <= nxt_scan_include;
            dwell_hi_ff <= nxt_dwell_hi;
            dwell_lo_ff <= nxt_dwell_lo;
            dwell_sel_ff <= nxt_dwell_sel;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs to the scan engine and transmitter, all registered
    psd_cfg_s cfg_ff, nxt_cfg;
    logic [11:0] port_dwell_ff, nxt_port_dwell;

    // the value is latched at port arrival so a mid-dwell write cannot stretch the current port
    always_comb begin
        nxt_cfg.tx_level_code = nxt_tx_level_code;
        nxt_cfg.scan_include = nxt_scan_include;
        nxt_cfg.dwell_multiplier_low = {nxt_dwell_hi, nxt_dwell_lo};
        nxt_cfg.dwell_sel = nxt_dwell_sel;
        nxt_cfg.tx_clip_warn = (nxt_tx_level_code == `PSD_TXLVL_CLIP);
        nxt_port_dwell = port_dwell_ff;
        if (port_arrive && dwell_sel_ff == `PSD_DWSEL_USER) begin
            nxt_port_dwell = {dwell_hi_ff, dwell_lo_ff};
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cfg_ff <= '{tx_level_code: `PSD_TXLVL_RST, scan_include: `PSD_MASK_RST,
                        dwell_multiplier_low: {`PSD_DWHI_RST, `PSD_DWLO_RST}, dwell_sel: `PSD_DWSEL_RST,
                        tx_clip_warn: 1'b0};
            port_dwell_ff <= {`PSD_DWHI_RST, `PSD_DWLO_RST};
        end else begin
            cfg_ff <= nxt_cfg;
            port_dwell_ff <= nxt_port_dwell;
        end
    end

    assign cfg = cfg_ff;
    assign port_dwell_bits = port_dwell_ff;

    ////////////////////////////////////////////////////////////////////////////
    // read channel, one cycle after the address is taken
    logic rvalid_ff, nxt_rvalid;
    logic [31:0] rdata_ff, nxt_rdata;
    logic [1:0] rresp_ff, nxt_rresp;
    logic arready_ff, nxt_arready;

    always_comb begin
        nxt_rvalid = rvalid_ff;
        nxt_rdata = rdata_ff;
        nxt_rresp = rresp_ff;
        if (rvalid_ff && s_axi_rready) begin
            nxt_rvalid = 1'b0;
        end
        if (s_axi_arvalid && !rvalid_ff) begin
            nxt_rvalid = 1'b1;
            nxt_rresp = `PSD_RESP_OKAY;
            case (s_axi_araddr)
                `PSD_OFF_TXLVL: nxt_rdata = {28'h0000000, tx_level_code_ff};
                `PSD_OFF_PSEL: nxt_rdata = {24'h000000, dwell_hi_ff, scan_include_ff};
                `PSD_OFF_DWLO: nxt_rdata = {24'h000000, dwell_lo_ff};
                `PSD_OFF_DWSEL: nxt_rdata = {30'h00000000, dwell_sel_ff};
                default: begin
                    nxt_rdata = 32'h0000_0000;
                    nxt_rresp = `PSD_RESP_SLVERR;
                end
            endcase
        end
        nxt_arready = !nxt_rvalid;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
            rresp_ff <= `PSD_RESP_OKAY;
            arready_ff <= 1'b1;
        end else begin
            rvalid_ff <= nxt_rvalid;
            arready_ff <= nxt_arready;
            rdata_ff <= nxt_rdata;
            rresp_ff <= nxt_rresp;
        end
    end

    assign s_axi_arready = arready_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;
endmodule : psd_cfg

// ### psd_cfg_properties.sv
// assertions for the scan/dwell/tx level slice, bound to psd_cfg
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ps
module psd_cfg_properties (
    input wire logic clk,
    input wire logic rst,
    input wire logic s_axi_awready,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic port_arrive,
    input wire psd_pkg::psd_cfg_s cfg,
    input wire logic [11:0] port_dwell_bits
);
    import psd_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////////////////////
    property p_rst; $past(rst) |-> cfg.tx_level_code == 4'h7 && cfg.dwell_multiplier_low == 12'h052; endproperty
    a_rst: assert property (p_rst) else $error("reset values wrong");
    property p_clip; cfg.tx_clip_warn == (cfg.tx_level_code == 4'he); endproperty
    a_clip: assert property (p_clip) else $error("clip warning wrong");
    // settings move only with a write response, never on their own
    property p_upd; $changed(cfg) |-> $rose(s_axi_bvalid); endproperty
    a_upd: assert property (p_upd) else $error("cfg changed without write");
    property p_user; port_arrive && cfg.dwell_sel == 2'h3 |=> port_dwell_bits == $past(cfg.dwell_multiplier_low); endproperty
    a_user: assert property (p_user) else $error("dwell not sampled");
    property p_keep; port_arrive && cfg.dwell_sel != 2'h3 |=> $stable(port_dwell_bits); endproperty
    a_keep: assert property (p_keep) else $error("dwell sampled off user mode");
    property p_bdone; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
    a_bdone: assert property (p_bdone) else $error("bvalid stuck");
    property p_rdone; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
    a_rdone: assert property (p_rdone) else $error("rvalid stuck");
    property p_wrdy; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
    a_wrdy: assert property (p_wrdy) else $error("write taken during response");
    property p_rdat; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0 && s_axi_arready == 1'b0; endproperty
    a_rdat: assert property (p_rdat) else $error("read word upper bits set");
endmodule : psd_cfg_properties
bind psd_cfg psd_cfg_properties psd_cfg_properties_i (
    .clk(clk),
    .rst(rst),
    .s_axi_awready(s_axi_awready),
    .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .port_arrive(port_arrive),
    .cfg(cfg),
    .port_dwell_bits(port_dwell_bits)
);

// ### test_port_scan_dwell_txpower_cfg.sv
// self-checking bench for psd_cfg over axi4-lite
// assumes psd_regs.svh beside it; response ready held high throughout
`timescale 1ns/1ps
`include "psd_regs.svh"
module test_port_scan_dwell_txpower_cfg;
    import psd_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0, port_arrive = 0;
    logic s_axi_bready = 1'b1, s_axi_rready = 1'b1;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    psd_cfg_s cfg;
    logic [11:0] port_dwell_bits;
    int num_errors = 0;
    int samples_checked = 0;
    psd_cfg psd_cfg_i (
        .clk(clk),
        .rst(rst),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .port_arrive(port_arrive),
        .cfg(cfg),
        .port_dwell_bits(port_dwell_bits)
    );
    initial forever #20 clk = ~clk;
    ////////////////////////////////////////////////////////////////////////////////
    task chk(input string n, input logic [31:0] s, input logic [31:0] e);
        samples_checked++;
        if (s !== e) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    // address and data offered together, each dropped once taken
    task wr(input logic [11:0] a, input logic [31:0] v);
        logic ta, tw;
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        @(negedge clk);
        while (s_axi_awvalid || s_axi_wvalid) begin
            ta = s_axi_awvalid && s_axi_awready;
            tw = s_axi_wvalid && s_axi_wready;
            @(posedge clk);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
            @(negedge clk);
        end
        while (!s_axi_bvalid) @(negedge clk);
        r = s_axi_bresp;
        @(posedge clk);
    endtask : wr
    task rd(input logic [11:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        @(negedge clk);
        while (!s_axi_arready) @(negedge clk);
        @(posedge clk);
        s_axi_arvalid <= 1'b0;
        @(negedge clk);
        while (!s_axi_rvalid) @(negedge clk);
        d = s_axi_rdata;
        r = s_axi_rresp;
        @(posedge clk);
    endtask : rd
    task rc(input logic [11:0] a, input logic [31:0] e);
        rd(a);
        chk("rdata", d, e);
        chk("rresp", 32'(r), 32'h0);
    endtask : rc
    task arrive;
        port_arrive <= 1'b1;
        @(posedge clk);
        port_arrive <= 1'b0;
        @(posedge clk);
    endtask : arrive
    task conclude;
        $display("checks %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : conclude
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        rc(`PSD_OFF_TXLVL, 32'h7);
        rc(`PSD_OFF_PSEL, 32'hf);
        rc(`PSD_OFF_DWLO, 32'h52);
        rc(`PSD_OFF_DWSEL, 32'h1);
        chk("dwell_sel", 32'(cfg.dwell_sel), 32'h1);
        // every level code, masks and upper nibble moved apart
        for (int i = 0; i < 16; i++) begin
            wr(`PSD_OFF_TXLVL, 32'(i));
            chk("bresp", 32'(r), 32'h0);
            rc(`PSD_OFF_TXLVL, 32'(i));
            chk("tx_clip_warn", 32'(cfg.tx_clip_warn), 32'(i == 14));
            wr(`PSD_OFF_PSEL, 32'((15 - i) * 16 + i));
            rc(`PSD_OFF_PSEL, 32'((15 - i) * 16 + i));
            chk("scan_include", 32'(cfg.scan_include), 32'(i));
            chk("dwell_multiplier_low", 32'(cfg.dwell_multiplier_low), 32'((15 - i) * 256 + 82));
        end
        // a write with byte lane 0 off must leave the level code alone
        s_axi_wstrb <= 4'he;
        wr(`PSD_OFF_TXLVL, 32'h3);
        s_axi_wstrb <= 4'hf;
        chk("bresp", 32'(r), 32'h0);
        rc(`PSD_OFF_TXLVL, 32'hf);
        wr(`PSD_OFF_DWLO, 32'ha5);
        wr(`PSD_OFF_PSEL, 32'hc3);
        arrive;
        chk("port_dwell_bits", 32'(port_dwell_bits), 32'h52);
        wr(`PSD_OFF_DWSEL, 32'h3);
        rc(`PSD_OFF_DWSEL, 32'h3);
        chk("dwell_sel", 32'(cfg.dwell_sel), 32'h3);
        arrive;
        chk("port_dwell_bits", 32'(port_dwell_bits), 32'hca5);
        wr(`PSD_OFF_DWLO, 32'h5a);
        arrive;
        chk("port_dwell_bits", 32'(port_dwell_bits), 32'hc5a);
        wr(12'h020, 32'hff);
        chk("bresp", 32'(r), 32'h2);
        rd(12'h020);
        chk("rresp", 32'(r), 32'h2);
        chk("rdata", d, 32'h0);
        // second reset in mid-run must bring the level code back
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rc(`PSD_OFF_TXLVL, 32'h7);
        rc(`PSD_OFF_DWLO, 32'h52);
        rc(`PSD_OFF_PSEL, 32'hf);
        chk("scan_include", 32'(cfg.scan_include), 32'hf);
        chk("port_dwell_bits", 32'(port_dwell_bits), 32'h52);
        conclude;
    end
    initial begin
        #100000;
        num_errors++;
        conclude;
    end
endmodule : test_port_scan_dwell_txpower_cfg
